//--- rtl/cts_pkg.sv
// Shared constants: register map, field positions, reset values, timings, bus states.
// Assumes a single 200 MHz system clock and a word-addressed register bus.
package cts_pkg;

    // Channel and input counts, extension select field width.
    localparam int NUM_ITC = 16;
    localparam int MAX_INPUTS = 8;
    localparam int EXT_SEL_W = 3;

    // Timing: clock period, pulser resolution and the derived tick length.
    localparam int CLK_PERIOD_NS = 5;
    localparam int PULSER_RES_NS = 10;
    localparam int PULSER_TICK_CYCLES = (PULSER_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXT_MUX_LATENCY = 2;

    // Input conditioning sizes.
    localparam int SPIKE_CNT_W = 4;
    localparam int DELAY_LINE_W = 15;

    // Register word addresses.
    localparam logic [5:0] ADDR_CHAN_CTRL = 6'h00;
    localparam logic [5:0] ADDR_STATUS = 6'h01;
    localparam logic [5:0] ADDR_INPUT_CFG = 6'h02;
    localparam logic [5:0] ADDR_EXT_SEL = 6'h0A;
    localparam logic [5:0] ADDR_PERIPH_MASK = 6'h0B;
    localparam logic [5:0] ADDR_COIN_CFG = 6'h0C;
    localparam logic [5:0] ADDR_PERIOD = 6'h0E;
    localparam logic [5:0] ADDR_RAND_THRESH = 6'h0F;
    localparam logic [5:0] ADDR_TYPE_LO = 6'h10;
    localparam logic [5:0] ADDR_TYPE_HI = 6'h11;

    // Field positions inside the input and coincidence configuration words.
    localparam int CFG_THR_LSB = 0;
    localparam int CFG_DLY_LSB = 4;
    localparam int CFG_INV_BIT = 8;
    localparam int COIN_EDGE_LSB = 0;
    localparam int COIN_INH_LSB = 8;
    localparam int COIN_WIN_LSB = 16;

    // Values after reset, and the CRC polynomial.
    localparam logic [31:0] CHAN_CTRL_RST = 32'h0000_0000;
    localparam logic [8:0] INPUT_CFG_RST = 9'h000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [31:0] CRC_SEED = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;

    // Register bus handshake states, one-hot.
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

endpackage

//--- rtl/trig_input_module.sv
// Input conditioning for one trigger source: inverter, spike filter, delay line.
// Assumes the input is already registered in the system clock domain.
`timescale 1ns/100ps
module trig_input_module (
    input wire logic clk,
    input wire logic reset,
    input wire logic sig_in,
    input wire logic invert,
    input wire logic [3:0] spike_thr,
    input wire logic [3:0] delay_sel,
    output logic sig_out
);
    typedef struct packed {
        logic [cts_pkg::SPIKE_CNT_W-1:0] cnt;
        logic valid;
        logic [cts_pkg::DELAY_LINE_W-1:0] line;
        logic out;
    } im_state_t;

    im_state_t r_reg;
    im_state_t r_next;
    logic s;

    // Inverter, saturating spike counter, shift register and tap selection.
    always_comb begin
        r_next = r_reg;
        s = sig_in ^ invert;
        if (s) begin
            if (r_reg.cnt != 4'hF) begin
                r_next.cnt = r_reg.cnt + 4'h1;
            end
        end else begin
            r_next.cnt = 4'h0;
        end
        r_next.valid = s && (r_next.cnt > spike_thr);
        r_next.line = {r_reg.line[cts_pkg::DELAY_LINE_W-2:0], r_reg.valid};
        if (delay_sel == 4'h0) begin
            r_next.out = r_reg.valid;
        end else begin
            r_next.out = r_reg.line[delay_sel - 4'h1];
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign sig_out = r_reg.out;
endmodule

//--- rtl/trig_coincidence.sv
// Coincidence unit: edge-started window pulses per input plus a level inhibit mask.
// Assumes its inputs are input-module outputs in the system clock domain.
`timescale 1ns/100ps
module trig_coincidence #(
    parameter int N = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] in_sig,
    input wire logic [N-1:0] edge_mask,
    input wire logic [N-1:0] inh_mask,
    input wire logic [7:0] window,
    output logic hit
);
    typedef struct packed {
        logic [N-1:0] prev;
        logic [N-1:0][7:0] cnt;
        logic hit;
    } co_state_t;

    co_state_t r_reg;
    co_state_t r_next;
    logic [N-1:0][7:0] cnt_nx;
    logic [N-1:0] pulse;

    // One window counter per input, loaded at a rising edge.
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_win
            assign cnt_nx[i] = (in_sig[i] && !r_reg.prev[i]) ? window :
                (r_reg.cnt[i] != 8'h00) ? r_reg.cnt[i] - 8'h01 : 8'h00;
            assign pulse[i] = (r_reg.cnt[i] != 8'h00);
        end
    endgenerate

    // Edge overlap gated by the inhibit levels; an empty mask drops its term.
    always_comb begin
        r_next = r_reg;
        r_next.prev = in_sig;
        r_next.cnt = cnt_nx;
        r_next.hit = ((edge_mask | inh_mask) != '0) &&
            ((pulse | ~edge_mask) == '1) &&
            ((in_sig | ~inh_mask) == '1);
    end

    // State register.
    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hit = r_reg.hit;
endmodule

//--- rtl/trigger_channel_logic.sv
// Trigger decision logic: sixteen internal trigger channels fed by input modules,
// extension multiplexers, peripheral requests, coincidence units and pulsers.
// Assumes synchronous inputs, one 200 MHz clock and an Avalon-MM master.
//
// The address map and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/100ps

// Overview of operation
// - Sixteen internal trigger channels, each carrying at most one source.
// - All channels disabled after reset until software enables them.
// - Each channel reacts to rising edges or to high levels.
// - An enabled active channel raises the trigger; disabled ones never do.
// - Event type is the type of the lowest-numbered firing channel.
// - Spike filter uses a four-bit counter cleared when the input is low.
// - A pulse passes once the count exceeds threshold T, delaying it T cycles.
// - Each input module has a fifteen-stage delay line with a tap multiplexer.
// - Extension inputs feed ordinary input modules in the upper slots.
// - The extension multiplexer adds exactly two clock cycles of latency.
// - A bitmask selects peripheral requests; any selected one fires one channel.
// - Coincidence: edge-started window pulses of selected inputs must overlap.
// - Inhibit mask inputs must be high to pass an edge coincidence.
// - With one mask empty the unit acts on edges or levels alone.
// - Periodic pulser asserts, then pauses; 10 ns steps, up to about 42.9 s.
// - Random numbers come from a 32-bit CRC fed a constant word.
// - Each cycle the random number below the threshold emits an event.
// - Each input module has a configurable inverter.
// - Coincidence units take only input module outputs.
// - External trigger inputs are registered before their input module.
// - Control word: low sixteen bits enable, upper sixteen choose edge mode.
module trigger_channel_logic #(
    parameter int N_IN = 4,
    parameter int N_EXT = 2,
    parameter int N_EXT_SRC = 8,
    parameter int N_PERIPH = 4,
    parameter int N_COIN = 2,
    parameter logic [31:0] RAND_DATA = 32'h5A5A_A5A5
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [N_IN-1:0] trig_in,
    input wire logic [N_EXT_SRC-1:0] ext_in,
    input wire logic [N_PERIPH-1:0] peripheral_trigger_request,
    output logic trigger_out,
    output logic [3:0] trigger_type,
    output logic [15:0] trigger_mask
);
    // Channel assignment: input modules first, extension slots on top of them.
    localparam int N_MOD = N_IN + N_EXT;
    localparam int CH_PERIPH = N_MOD;
    localparam int CH_COIN = CH_PERIPH + 1;
    localparam int CH_PERIODIC = CH_COIN + N_COIN;
    localparam int CH_RANDOM = CH_PERIODIC + 1;

    typedef struct packed {
        cts_pkg::bus_state_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [31:0] chan_ctrl;
        logic [cts_pkg::MAX_INPUTS-1:0][8:0] in_cfg;
        logic [31:0] ext_sel;
        logic [31:0] periph_mask;
        logic [1:0][31:0] coin_cfg;
        logic [31:0] period;
        logic [31:0] rand_thr;
        logic [63:0] types;
        logic [N_IN-1:0] in_sync;
        logic [N_EXT-1:0] ext_s1;
        logic [N_EXT-1:0] ext_s2;
        logic [N_PERIPH-1:0] periph_sync;
        logic periph_hit;
        logic [cts_pkg::NUM_ITC-1:0] prev;
        logic [3:0] tick_cnt;
        logic [31:0] pcount;
        logic pulse;
        logic [31:0] crc;
        logic rnd;
        logic trig;
        logic [3:0] ttype;
        logic [15:0] tmask;
    } top_state_t;

    top_state_t r_reg;
    top_state_t r_next;
    logic [N_MOD-1:0] mod_out;
    logic [N_MOD-1:0] mod_in;
    logic [cts_pkg::MAX_INPUTS-1:0] coin_src;
    logic [N_COIN-1:0] coin_hit;
    logic [cts_pkg::NUM_ITC-1:0] chan_src;
    logic [cts_pkg::NUM_ITC-1:0] chan_act;
    logic [cts_pkg::NUM_ITC-1:0] fired;
    logic tick;

    // One CRC-32 step over a full data word, bit by bit.
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] x;
        x = c;
        for (int b = 31; b >= 0; b--) begin
            if (x[31] ^ d[b]) begin
                x = {x[30:0], 1'b0} ^ cts_pkg::CRC_POLY;
            end else begin
                x = {x[30:0], 1'b0};
            end
        end
        return x;
    endfunction

    // Register read multiplexer; unmapped addresses read as zero.
    function automatic logic [31:0] read_mux(input top_state_t s, input logic [5:0] a);
        logic [31:0] v;
        logic [5:0] k;
        v = 32'h0000_0000;
        k = a - cts_pkg::ADDR_INPUT_CFG;
        if (a >= cts_pkg::ADDR_INPUT_CFG && k < 6'(cts_pkg::MAX_INPUTS)) begin
            v = {23'h000000, s.in_cfg[k[2:0]]};
        end else begin
            case (a)
                cts_pkg::ADDR_CHAN_CTRL: v = s.chan_ctrl;
                cts_pkg::ADDR_STATUS: v = {11'h000, s.trig, s.ttype, s.tmask};
                cts_pkg::ADDR_EXT_SEL: v = s.ext_sel;
                cts_pkg::ADDR_PERIPH_MASK: v = s.periph_mask;
                cts_pkg::ADDR_COIN_CFG: v = s.coin_cfg[0];
                cts_pkg::ADDR_COIN_CFG + 6'h01: v = s.coin_cfg[1];
                cts_pkg::ADDR_PERIOD: v = s.period;
                cts_pkg::ADDR_RAND_THRESH: v = s.rand_thr;
                cts_pkg::ADDR_TYPE_LO: v = s.types[31:0];
                cts_pkg::ADDR_TYPE_HI: v = s.types[63:32];
                default: v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // Sources of the input modules: sampled trigger pins below, extension slots above.
    assign mod_in = {r_reg.ext_s2, r_reg.in_sync};

    // One input module per slot, configured by its own word.
    genvar m;
    generate
        for (m = 0; m < N_MOD; m++) begin : g_mod
            trig_input_module u_im (
                .clk(clk),
                .reset(reset),
                .sig_in(mod_in[m]),
                .invert(r_reg.in_cfg[m][cts_pkg::CFG_INV_BIT]),
                .spike_thr(r_reg.in_cfg[m][cts_pkg::CFG_THR_LSB +: 4]),
                .delay_sel(r_reg.in_cfg[m][cts_pkg::CFG_DLY_LSB +: 4]),
                .sig_out(mod_out[m])
            );
        end
    endgenerate

    // Coincidence units see input-module outputs only, zero-padded to the mask width.
    assign coin_src = cts_pkg::MAX_INPUTS'(mod_out);

    genvar c;
    generate
        for (c = 0; c < N_COIN; c++) begin : g_coin
            trig_coincidence #(
                .N(cts_pkg::MAX_INPUTS)
            ) u_co (
                .clk(clk),
                .reset(reset),
                .in_sig(coin_src),
                .edge_mask(r_reg.coin_cfg[c][cts_pkg::COIN_EDGE_LSB +: 8]),
                .inh_mask(r_reg.coin_cfg[c][cts_pkg::COIN_INH_LSB +: 8]),
                .window(r_reg.coin_cfg[c][cts_pkg::COIN_WIN_LSB +: 8]),
                .hit(coin_hit[c])
            );
        end
    endgenerate

    // Channel source map; unused channels carry a constant low.
    always_comb begin
        chan_src = '0;
        chan_src[N_MOD-1:0] = mod_out;
        chan_src[CH_PERIPH] = r_reg.periph_hit;
        chan_src[CH_COIN +: N_COIN] = coin_hit;
        chan_src[CH_PERIODIC] = r_reg.pulse;
        chan_src[CH_RANDOM] = r_reg.rnd;
    end

    // Per-channel edge or level sensitivity, then the enable mask.
    always_comb begin
        for (int i = 0; i < cts_pkg::NUM_ITC; i++) begin
            if (r_reg.chan_ctrl[16 + i]) begin
                chan_act[i] = chan_src[i] && !r_reg.prev[i];
            end else begin
                chan_act[i] = chan_src[i];
            end
        end
        fired = chan_act & r_reg.chan_ctrl[15:0];
    end

    // Pulser time base: one enable pulse every 10 ns.
    assign tick = (r_reg.tick_cnt == 4'(cts_pkg::PULSER_TICK_CYCLES - 1));

    // Next-state logic for the bus slave, configuration and trigger path.
    always_comb begin
        r_next = r_reg;

        // Bus slave: latch read data, drop waitrequest for one cycle, then write.
        case (r_reg.bus)
            cts_pkg::BUS_IDLE: begin
                r_next.waitreq = 1'b1;
                if (avs_read || avs_write) begin
                    r_next.bus = cts_pkg::BUS_ACK;
                    r_next.waitreq = 1'b0;
                    r_next.rdata = read_mux(r_reg, avs_address);
                end
            end
            cts_pkg::BUS_ACK: begin
                r_next.bus = cts_pkg::BUS_IDLE;
                r_next.waitreq = 1'b1;
                if (avs_write) begin
                    if (avs_address >= cts_pkg::ADDR_INPUT_CFG &&
                        avs_address < cts_pkg::ADDR_INPUT_CFG + 6'(cts_pkg::MAX_INPUTS)) begin
                        r_next.in_cfg[3'(avs_address - cts_pkg::ADDR_INPUT_CFG)] = avs_writedata[8:0];
                    end
                    case (avs_address)
                        cts_pkg::ADDR_CHAN_CTRL: r_next.chan_ctrl = avs_writedata;
                        cts_pkg::ADDR_EXT_SEL: r_next.ext_sel = avs_writedata;
                        cts_pkg::ADDR_PERIPH_MASK: r_next.periph_mask = avs_writedata;
                        cts_pkg::ADDR_COIN_CFG: r_next.coin_cfg[0] = avs_writedata;
                        cts_pkg::ADDR_COIN_CFG + 6'h01: r_next.coin_cfg[1] = avs_writedata;
                        cts_pkg::ADDR_PERIOD: r_next.period = avs_writedata;
                        cts_pkg::ADDR_RAND_THRESH: r_next.rand_thr = avs_writedata;
                        cts_pkg::ADDR_TYPE_LO: r_next.types[31:0] = avs_writedata;
                        cts_pkg::ADDR_TYPE_HI: r_next.types[63:32] = avs_writedata;
                        default: r_next.rdata = r_reg.rdata;
                    endcase
                end
            end
            default: begin
                r_next.bus = cts_pkg::BUS_IDLE;
                r_next.waitreq = 1'b1;
            end
        endcase

        // Sample the trigger pins once before their input modules.
        r_next.in_sync = trig_in;

        // Extension multiplexer: select stage, then a second stage for fixed latency.
        for (int j = 0; j < N_EXT; j++) begin
            r_next.ext_s1[j] = ext_in[r_reg.ext_sel[j * cts_pkg::EXT_SEL_W +: cts_pkg::EXT_SEL_W]];
        end
        r_next.ext_s2 = r_reg.ext_s1;

        // Peripheral requests are sampled, masked and ORed onto one channel.
        r_next.periph_sync = peripheral_trigger_request;
        r_next.periph_hit = |(r_reg.periph_sync & r_reg.periph_mask[N_PERIPH-1:0]);

        // Periodic pulser: high for one 10 ns step, then a pause of period steps.
        r_next.tick_cnt = tick ? 4'h0 : r_reg.tick_cnt + 4'h1;
        if (tick) begin
            if (r_reg.pcount >= r_reg.period) begin
                r_next.pcount = 32'h0000_0000;
                r_next.pulse = 1'b1;
            end else begin
                r_next.pcount = r_reg.pcount + 32'h0000_0001;
                r_next.pulse = 1'b0;
            end
        end

        // Pseudo-random pulser: CRC advances every cycle and is compared with the threshold.
        r_next.crc = crc_step(r_reg.crc, RAND_DATA);
        r_next.rnd = (r_reg.crc < r_reg.rand_thr);

        // Trigger decision: any fired channel, lowest channel picks the type.
        r_next.prev = chan_src;
        r_next.trig = |fired;
        r_next.tmask = fired;
        r_next.ttype = 4'h0;
        for (int i = cts_pkg::NUM_ITC - 1; i >= 0; i--) begin
            if (fired[i]) begin
                r_next.ttype = r_reg.types[i * 4 +: 4];
            end
        end
    end

    // State register with reset values; every channel starts disabled.
    always_ff @(posedge clk) begin
        if (reset) begin
            r_reg <= '0;
            r_reg.bus <= cts_pkg::BUS_IDLE;
            r_reg.waitreq <= 1'b1;
            r_reg.chan_ctrl <= cts_pkg::CHAN_CTRL_RST;
            r_reg.crc <= cts_pkg::CRC_SEED;
            r_reg.period <= cts_pkg::WORD_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register.
    assign avs_readdata = r_reg.rdata;
    assign avs_waitrequest = r_reg.waitreq;
    assign trigger_out = r_reg.trig;
    assign trigger_type = r_reg.ttype;
    assign trigger_mask = r_reg.tmask;
endmodule

//--- verif/trigger_channel_asserts.sv
// Checker: bus handshake and trigger output relations.
// Assumes it is bound into the top module and sees only that module's ports.
`timescale 1ns/100ps
module trigger_channel_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic trigger_out,
    input wire logic [3:0] trigger_type,
    input wire logic [15:0] trigger_mask
);
    logic [15:0] en_reg;
    logic [15:0] en_prev_reg;
    logic [15:0] en_old_reg;

    // Enable shadow plus two older copies for the write pipeline.
    always_ff @(posedge clk) begin
        if (reset) begin
            en_reg <= 16'h0000;
            en_prev_reg <= 16'h0000;
            en_old_reg <= 16'h0000;
        end else begin
            en_prev_reg <= en_reg;
            en_old_reg <= en_prev_reg;
            if (avs_write && !avs_waitrequest && avs_address == cts_pkg::ADDR_CHAN_CTRL) begin
                en_reg <= avs_writedata[15:0];
            end
        end
    end

    // All checks run on the system clock and pause during reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_unmapped_read;
        avs_read && avs_waitrequest && avs_address == 6'h3F ##1 !avs_waitrequest;
    endsequence

    property p_ack_next;
        s_taken |=> !avs_waitrequest;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_no_idle_ack;
        !avs_read && !avs_write |=> avs_waitrequest;
    endproperty
    a_no_idle_ack: assert property (p_no_idle_ack) else $error("answer without a request");
    property p_ack_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("answer too long");
    property p_unmapped;
        s_unmapped_read |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_trig_mask;
        trigger_out == (trigger_mask != 16'h0000);
    endproperty
    a_trig_mask: assert property (p_trig_mask) else $error("trigger vs mask");
    property p_type_idle;
        trigger_mask == 16'h0000 |-> trigger_type == 4'h0;
    endproperty
    a_type_idle: assert property (p_type_idle) else $error("type without channel");
    property p_disabled;
        (trigger_mask & ~(en_reg | en_prev_reg | en_old_reg)) == 16'h0000;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled channel fired");
    property p_rst_clear;
        $fell(reset) |-> !trigger_out && trigger_mask == 16'h0000 && avs_waitrequest;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("outputs not reset");
endmodule

bind trigger_channel_logic trigger_channel_asserts i_trigger_channel_asserts (.clk, .reset, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .trigger_out, .trigger_type, .trigger_mask);

//--- verif/periph_net_model.sv
// Peripheral model: raises one request line, releases it later.
// Assumes the block's trigger output stands for the trigger arriving over the network.
`timescale 1ns/100ps
module periph_net_model #(
    parameter int N = 4,
    parameter int HOLD_MAX = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic [1:0] line,
    input wire logic trigger_out,
    output logic [N-1:0] req
);
    int hold;

    // A request stands two cycles or more, then drops on the trigger or at the hold limit.
    always_ff @(posedge clk) begin
        if (reset) begin
            req <= '0;
            hold <= 0;
        end else if (go) begin
            req <= N'(1) << line;
            hold <= 0;
        end else if (req != '0) begin
            hold <= hold + 1;
            if ((hold >= 1 && trigger_out) || hold >= HOLD_MAX) begin
                req <= '0;
            end
        end
    end
endmodule

//--- verif/tb_top.sv
// Self-checking bench: register access and trigger paths.
// Assumes package, design, checker and model compile first.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd_data;
    logic avs_waitrequest, trigger_out;
    logic [3:0] trig_in = 4'h0, peripheral_trigger_request, trigger_type;
    logic [7:0] ext_in = 8'h00;
    logic [15:0] trigger_mask;
    logic [1:0] line = 2'h0;
    int fail_count = 0, n_checks = 0, cyc = 0, k;

    trigger_channel_logic i_trigger_channel_logic (.clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .trig_in, .ext_in, .peripheral_trigger_request,
        .trigger_out, .trigger_type, .trigger_mask);
    periph_net_model i_periph_net_model (.clk, .reset, .go, .line, .trigger_out,
        .req(peripheral_trigger_request));

    // System clock at 200 MHz.
    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One bus access, held until waitrequest is seen low.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd_data = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Counts trigger-high cycles.
    task automatic count_hi(input int n);
        k = 0;
        repeat (n) begin
            @(posedge clk);
            k += (trigger_out === 1'b1);
        end
    endtask

    // Edges from the stimulus until the trigger shows.
    task automatic lat();
        k = -1;
        while (trigger_out !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        trig_in <= 4'h0;
        ext_in <= 8'h00;
    endtask

    // Requests on one peripheral line and counts trigger cycles.
    task automatic req(input logic [1:0] l);
        line <= l;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        count_hi(24);
    endtask

    // Coincidence unit 0 on channel 7: input 0 rises, input 1 rises gap cycles later.
    task automatic coin(input logic [31:0] cfg, input int gap, input logic inh, input logic exp);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_COIN_CFG, cfg);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0080);
        trig_in[2] <= inh;
        @(posedge clk);
        trig_in[0] <= 1'b1;
        repeat (gap) @(posedge clk);
        trig_in[1] <= 1'b1;
        count_hi(16);
        chk("coincidence", {31'h0, exp}, {31'h0, k != 0});
    endtask

    // Timeout at 20000 cycles; the tests need under a thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        do_reset();
        bus(1'b0, cts_pkg::ADDR_CHAN_CTRL, 32'h0);
        chk("control after reset", cts_pkg::CHAN_CTRL_RST, rd_data);
        bus(1'b0, 6'h3F, 32'h0);
        chk("unmapped read", 32'h0000_0000, rd_data);
        trig_in <= 4'h1;
        count_hi(12);
        chk("disabled channel", 0, k);
        trig_in <= 4'h0;
        bus(1'b1, cts_pkg::ADDR_TYPE_LO, 32'h0000_0053);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0001);
        trig_in <= 4'h1;
        lat();
        chk("input latency", 4, k);
        bus(1'b1, cts_pkg::ADDR_INPUT_CFG + 6'h01, 32'h0000_0100);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0003);
        repeat (8) @(posedge clk);
        bus(1'b0, cts_pkg::ADDR_STATUS, 32'h0);
        chk("status two channels", 32'h0013_0003, rd_data);
        trig_in <= 4'h0;
        repeat (8) @(posedge clk);
        bus(1'b1, cts_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        bus(1'b0, cts_pkg::ADDR_STATUS, 32'h0);
        chk("status channel one", 32'h0015_0002, rd_data);
        chk("type pin", 5, trigger_type);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0001);
        bus(1'b1, cts_pkg::ADDR_INPUT_CFG, 32'h0000_0032);
        trig_in <= 4'h1;
        repeat (2) @(posedge clk);
        trig_in <= 4'h0;
        count_hi(20);
        chk("short pulse", 0, k);
        trig_in <= 4'h1;
        lat();
        chk("filtered latency", 9, k);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0001_0001);
        trig_in <= 4'h1;
        count_hi(16);
        chk("edge mode cycles", 1, k);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_EXT_SEL, 32'h0000_0005);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0010);
        ext_in <= 8'hDF;
        count_hi(12);
        chk("unselected extension", 0, k);
        ext_in <= 8'hFF;
        lat();
        chk("extension latency", 5, k);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_PERIPH_MASK, 32'h0000_0002);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0040);
        req(2'h0);
        chk("masked request", 0, k);
        req(2'h1);
        chk("selected request", 1, k != 0);
        coin(32'h0004_0003, 2, 1'b0, 1'b1);
        coin(32'h0004_0003, 6, 1'b0, 1'b0);
        coin(32'h0004_0403, 2, 1'b0, 1'b0);
        coin(32'h0004_0403, 2, 1'b1, 1'b1);
        coin(32'h0000_0400, 2, 1'b1, 1'b1);
        coin(32'h0000_0400, 2, 1'b0, 1'b0);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_PERIOD, 32'h0000_0003);
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0200);
        repeat (8) @(posedge clk);
        count_hi(32);
        chk("pulser cycles", 8, k);
        do_reset();
        bus(1'b1, cts_pkg::ADDR_CHAN_CTRL, 32'h0000_0400);
        count_hi(40);
        chk("random zero", 0, k);
        bus(1'b1, cts_pkg::ADDR_RAND_THRESH, 32'h8000_0000);
        count_hi(200);
        chk("random mix", 1, k > 20 && k < 180);
        stop_test();
    end
endmodule
